// ### hdl/mpra_dly.sv
// Shift line that delays read requests, every stage visible
`timescale 1ns/1ps
`default_nettype none
module mpra_dly #(
    parameter int W = 5,
    parameter int D = 64
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [D*W-1:0] taps
);
    logic [D*W-1:0] taps_r;
    logic [D*W-1:0] taps_nxt;

    initial begin
        if (D < 2 || W < 1) begin
            $error("mpra_dly: depth below two");
        end
    end

    // Shift one stage per clock
    always_comb begin
        taps_nxt = {taps_r[(D-1)*W-1:0], din};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            taps_r <= '0;
        end else begin
            taps_r <= taps_nxt;
        end
    end

    assign taps = taps_r;
endmodule
`default_nettype wire

// ### hdl/mpra_pkg.sv
// Shared types and constants for the MPR access logic
package mpra_pkg;

    // ----------------------------------------
    // Command bus
    // ----------------------------------------
    typedef enum logic [2:0] {
        MPRA_OP_DES,
        MPRA_OP_MRS,
        MPRA_OP_RD,
        MPRA_OP_WR,
        MPRA_OP_REF,
        MPRA_OP_OTHER
    } mpra_op_t;

    typedef struct packed {
        mpra_op_t op;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] addr;
    } mpra_cmd_t;

    // Read request travelling down the latency line
    typedef struct packed {
        logic vld;
        logic chop;
        logic hi;
        logic [1:0] loc;
    } mpra_rdq_t;

    typedef enum logic {
        MPRA_IDLE,
        MPRA_BURST
    } mpra_burst_t;

    // ----------------------------------------
    // Mode register fields
    // ----------------------------------------
    localparam logic [2:0] MR_NUM_0 = 3'h0;
    localparam logic [2:0] MR_NUM_3 = 3'h3;
    localparam int MR0_BL_LSB = 0;
    localparam int MR3_PAGE_LSB = 0;
    localparam int MR3_EN_BIT = 2;
    localparam int MR3_FMT_LSB = 11;
    localparam int ADDR_BURST_HI_BIT = 2;
    localparam logic [1:0] BL_BC4_FIXED = 2'h2;
    localparam logic [1:0] FMT_STAGGER = 2'h2;
    localparam logic [1:0] PAGE_0 = 2'h0;
    localparam logic [2:0] LAST_BEAT = 3'h7;
    localparam logic [2:0] CHOP_BEAT = 3'h4;

    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam int CFG_CL_LSB = 0;
    localparam int CFG_AL_LSB = 8;
    localparam int CFG_PL_LSB = 16;
    localparam logic [4:0] CL_RST = 5'h0B;
    localparam logic [4:0] AL_RST = 5'h00;
    localparam logic [3:0] PL_RST = 4'h0;

    // ----------------------------------------
    // Pattern storage after reset
    // ----------------------------------------
    localparam logic [31:0] MPR_RST = 32'h000F3355;

endpackage

// ### hdl/mpra_store.sv
// Four eight-bit pattern locations of MPR page 0
`timescale 1ns/1ps
`default_nettype none
module mpra_store (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [1:0] wr_loc,
    input wire logic [7:0] wr_data,
    output logic [31:0] words
);
    logic [31:0] words_r;
    logic [31:0] words_nxt;

    // Replace the addressed byte on a write
    always_comb begin
        words_nxt = words_r;
        if (wr_en) begin
            words_nxt[{wr_loc, 3'h0} +: 8] = wr_data;
        end
    end

    // Contents survive everything but reset
    always_ff @(posedge clk) begin
        if (reset) begin
            words_r <= mpra_pkg::MPR_RST;
        end else begin
            words_r <= words_nxt;
        end
    end

    assign words = words_r;
endmodule
`default_nettype wire

// ### hdl/mpra_top.sv
// MPR access logic: mode, pattern writes, staggered read bursts
//
// How it works
// - staggered read of location n puts n+j (mod 4) on lane j.
// - back-to-back reads stream bursts with no idle beat between.
// - x8 lower nibble repeats the same location pattern as upper.
// - x16 lanes 8..15 carry the same locations as lanes 0..7.
// - burst chop four returns beats 0..3, then released lanes.
// - bank bits 00..11 pick location 0..3.
// - parity latency adds to read data delay when enabled.
// - MR3 bit 2 steers reads and writes to MPR; clear returns.
// - write stores A7..A0 into location, A7 on beat 0 onward.
// - written patterns stay until reset.
// - writes ignore A10, bank groups and other address bits.
// - burst starts AL plus CL (plus PL) cycles after read, for totals from 2 to MAX_RL+1.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module mpra_top #(
    parameter int DQ_W = 8,
    parameter int MAX_RL = 64
) (
    input wire logic clk,
    input wire logic reset,
    input wire mpra_pkg::mpra_cmd_t cmd,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe
);
    initial begin
        if (!(DQ_W == 4 || DQ_W == 8 || DQ_W == 16) || MAX_RL < 2 ||
            MAX_RL > 127) begin
            $error("mpra_top: unsupported width or latency depth");
        end
    end

    // ----------------------------------------
    // Mode state and command decode
    // ----------------------------------------
    logic mpr_en_r, mpr_en_nxt;
    logic [1:0] page_r, page_nxt;
    logic [1:0] fmt_r, fmt_nxt;
    logic [1:0] bl_r, bl_nxt;
    logic [2:0] mr_num;
    logic rd_acc, wr_acc;
    logic [7:0] wr_byte;

    assign mr_num = {cmd.bg[0], cmd.ba};
    assign rd_acc = cmd.op == mpra_pkg::MPRA_OP_RD && mpr_en_r;
    assign wr_acc = cmd.op == mpra_pkg::MPRA_OP_WR && mpr_en_r &&
                    page_r == mpra_pkg::PAGE_0;

    // Write byte reversed so A7 lands on beat 0 (bit 0)
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            wr_byte[k] = cmd.addr[7-k];
        end
    end

    // Mode register commands update the MPR controls
    always_comb begin
        mpr_en_nxt = mpr_en_r;
        page_nxt = page_r;
        fmt_nxt = fmt_r;
        bl_nxt = bl_r;
        if (cmd.op == mpra_pkg::MPRA_OP_MRS) begin
            if (mr_num == mpra_pkg::MR_NUM_3) begin
                mpr_en_nxt = cmd.addr[mpra_pkg::MR3_EN_BIT];
                page_nxt = cmd.addr[mpra_pkg::MR3_PAGE_LSB +: 2];
                fmt_nxt = cmd.addr[mpra_pkg::MR3_FMT_LSB +: 2];
            end else if (mr_num == mpra_pkg::MR_NUM_0) begin
                bl_nxt = cmd.addr[mpra_pkg::MR0_BL_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mpr_en_r <= 1'b0;
            page_r <= 2'h0;
            fmt_r <= 2'h0;
            bl_r <= 2'h0;
        end else begin
            mpr_en_r <= mpr_en_nxt;
            page_r <= page_nxt;
            fmt_r <= fmt_nxt;
            bl_r <= bl_nxt;
        end
    end

    // ----------------------------------------
    // Pattern storage and read latency line
    // ----------------------------------------
    logic [31:0] words;
    mpra_pkg::mpra_rdq_t rq_in, rq_tap;
    logic [MAX_RL*$bits(mpra_pkg::mpra_rdq_t)-1:0] taps;
    logic [4:0] cl_r, al_r;
    logic [3:0] pl_r;
    logic [6:0] rl;
    logic [6:0] tap_idx;

    mpra_store u_store (
        .clk(clk),
        .reset(reset),
        .wr_en(wr_acc),
        .wr_loc(cmd.ba),
        .wr_data(wr_byte),
        .words(words)
    );

    // Request carries location, chop and start half of the burst
    always_comb begin
        rq_in.vld = rd_acc;
        rq_in.chop = bl_r == mpra_pkg::BL_BC4_FIXED;
        rq_in.hi = cmd.addr[mpra_pkg::ADDR_BURST_HI_BIT];
        rq_in.loc = cmd.ba;
    end

    mpra_dly #(
        .W($bits(mpra_pkg::mpra_rdq_t)),
        .D(MAX_RL)
    ) u_dly (
        .clk(clk),
        .reset(reset),
        .din(rq_in),
        .taps(taps)
    );

    // Tap two stages early: one for the engine, one for the pin flop
    assign rl = 7'(cl_r) + 7'(al_r) + 7'(pl_r);
    always_comb begin
        if (rl < 7'h02) begin
            tap_idx = 7'h00;
        end else if (rl - 7'h02 > 7'(MAX_RL - 1)) begin
            tap_idx = 7'(MAX_RL - 1);
        end else begin
            tap_idx = rl - 7'h02;
        end
        rq_tap = taps[tap_idx*$bits(mpra_pkg::mpra_rdq_t) +:
                      $bits(mpra_pkg::mpra_rdq_t)];
    end

    // ----------------------------------------
    // Burst engine and lane driver
    // ----------------------------------------
    mpra_pkg::mpra_burst_t st_r, st_nxt;
    logic [2:0] beat_r, beat_nxt;
    logic [1:0] loc_r, loc_nxt;
    logic chop_r, chop_nxt, hi_r, hi_nxt;
    logic [DQ_W-1:0] dq_r, dq_nxt;
    logic oe_r, oe_nxt;

    // A new request restarts at beat 0 even on the last beat
    always_comb begin
        st_nxt = st_r;
        beat_nxt = beat_r;
        loc_nxt = loc_r;
        chop_nxt = chop_r;
        hi_nxt = hi_r;
        if (rq_tap.vld) begin
            st_nxt = mpra_pkg::MPRA_BURST;
            beat_nxt = 3'h0;
            loc_nxt = rq_tap.loc;
            chop_nxt = rq_tap.chop;
            hi_nxt = rq_tap.hi;
        end else begin
            case (st_r)
                mpra_pkg::MPRA_BURST: begin
                    if (beat_r == mpra_pkg::LAST_BEAT) begin
                        st_nxt = mpra_pkg::MPRA_IDLE;
                    end
                    beat_nxt = beat_r + 3'h1;
                end
                default: st_nxt = mpra_pkg::MPRA_IDLE;
            endcase
        end
    end

    // Each lane picks a location, rotated in staggered format; bit index is the beat, upper half first when hi is set
    always_comb begin
        logic [2:0] ub;
        logic [1:0] w;
        ub = 3'h0;
        w = 2'h0;
        dq_nxt = '0;
        oe_nxt = 1'b0;
        if (st_r == mpra_pkg::MPRA_BURST) begin
            ub = beat_r ^ {hi_r, 2'h0};
            oe_nxt = !(chop_r && beat_r >= mpra_pkg::CHOP_BEAT);
            for (int j = 0; j < DQ_W; j++) begin
                if (fmt_r == mpra_pkg::FMT_STAGGER) begin
                    w = loc_r + 2'(j % 4);
                end else begin
                    w = loc_r;
                end
                if (oe_nxt && page_r == mpra_pkg::PAGE_0) begin
                    dq_nxt[j] = words[{w, ub}];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= mpra_pkg::MPRA_IDLE;
            beat_r <= 3'h0;
            loc_r <= 2'h0;
            chop_r <= 1'b0;
            hi_r <= 1'b0;
            dq_r <= '0;
            oe_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            beat_r <= beat_nxt;
            loc_r <= loc_nxt;
            chop_r <= chop_nxt;
            hi_r <= hi_nxt;
            dq_r <= dq_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign dq_o = dq_r;
    assign dq_oe = oe_r;

    // ----------------------------------------
    // Wishbone register slave
    // ----------------------------------------
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [4:0] cl_nxt, al_nxt;
    logic [3:0] pl_nxt;
    logic [31:0] cfg_word, stat_word;

    assign cfg_word = {12'h0, pl_r, 3'h0, al_r, 3'h0, cl_r};
    assign stat_word = {24'h0, st_r == mpra_pkg::MPRA_BURST, bl_r,
                        fmt_r, page_r, mpr_en_r};

    // Ack one cycle after the strobe; writes land at the acked edge
    always_comb begin
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = dat_r;
        cl_nxt = cl_r;
        al_nxt = al_r;
        pl_nxt = pl_r;
        if (ack_nxt) begin
            case (wb_adr_i)
                mpra_pkg::REG_CFG: dat_nxt = cfg_word;
                mpra_pkg::REG_STAT: dat_nxt = stat_word;
                mpra_pkg::REG_DATA: dat_nxt = words;
                default: dat_nxt = 32'h0;
            endcase
        end
        if (ack_r && wb_cyc_i && wb_stb_i && wb_we_i &&
            wb_adr_i == mpra_pkg::REG_CFG) begin
            if (wb_sel_i[0]) begin
                cl_nxt = wb_dat_i[mpra_pkg::CFG_CL_LSB +: 5];
            end
            if (wb_sel_i[1]) begin
                al_nxt = wb_dat_i[mpra_pkg::CFG_AL_LSB +: 5];
            end
            if (wb_sel_i[2]) begin
                pl_nxt = wb_dat_i[mpra_pkg::CFG_PL_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            cl_r <= mpra_pkg::CL_RST;
            al_r <= mpra_pkg::AL_RST;
            pl_r <= mpra_pkg::PL_RST;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            cl_r <= cl_nxt;
            al_r <= al_nxt;
            pl_r <= pl_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [7:0] lat_r;
    logic lat_run_r;
    logic [31:0] words_q_r;

    // Cycles since the first read issued while none was being timed
    always_ff @(posedge clk) begin
        words_q_r <= words;
        if (reset) begin
            lat_r <= 8'h00;
            lat_run_r <= 1'b0;
        end else if (rd_acc && !lat_run_r) begin
            lat_r <= 8'h00;
            lat_run_r <= 1'b1;
        end else begin
            lat_r <= lat_r + 8'h01;
            if (oe_r && lat_run_r) begin
                lat_run_r <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_last_beat_restart;
        st_r == mpra_pkg::MPRA_BURST && beat_r == mpra_pkg::LAST_BEAT &&
        rq_tap.vld;
    endsequence

    AST_LATENCY: assert property ($rose(oe_r) && lat_run_r &&
        rl >= 7'h02 |-> 8'(rl) == lat_r)
        else $error("first data beat not at read latency");
    AST_NO_BUBBLE: assert property (s_last_beat_restart |=>
        st_r == mpra_pkg::MPRA_BURST && beat_r == 3'h0 ##1 oe_r)
        else $error("gap between back-to-back bursts");
    AST_STAGGER_LANE0: assert property (oe_nxt &&
        page_r == mpra_pkg::PAGE_0 |=>
        dq_r[0] == words_q_r[{$past(loc_r), $past(beat_r) ^
                             {$past(hi_r), 2'h0}}])
        else $error("lane 0 does not carry addressed location");
    AST_STAGGER_ROT: assert property (oe_r && fmt_r ==
        mpra_pkg::FMT_STAGGER && $past(loc_r) == loc_r &&
        $past(page_r) == mpra_pkg::PAGE_0 && !$past(rq_tap.vld) |->
        dq_r[1] == words_q_r[{2'($past(loc_r) + 2'h1),
                             $past(beat_r) ^ {$past(hi_r), 2'h0}}])
        else $error("lane 1 not rotated by one location");
    AST_NIBBLE_COPY: assert property (DQ_W >= 8 |->
        dq_r[3:0] == dq_r[DQ_W-1 -: 4])
        else $error("upper lanes differ from lane group 0");
    AST_CHOP_TRI: assert property (st_r == mpra_pkg::MPRA_BURST &&
        chop_r && beat_r == 3'h3 && !rq_tap.vld |=> ##1 !oe_r [*4])
        else $error("chopped burst drives beats 4 to 7");
    AST_MODE_OFF: assert property (cmd.op == mpra_pkg::MPRA_OP_RD &&
        !mpr_en_r |=> !taps[$bits(mpra_pkg::mpra_rdq_t)-1])
        else $error("read redirected while MPR mode off");
    AST_LOC_SEL: assert property (rd_acc |=>
        taps[1:0] == $past(cmd.ba))
        else $error("location not taken from bank bits");
    AST_WRITE: assert property (wr_acc |=>
        words[{$past(cmd.ba), 3'h0} +: 8] == $past(wr_byte))
        else $error("written byte not stored");
    AST_RETAIN: assert property (!wr_acc |=> $stable(words))
        else $error("pattern changed without a write");
endmodule
`default_nettype wire

// ### sim/mpra_ctl_model.sv
// Controller model that issues commands to the MPR access logic
`timescale 1ns/1ps
`default_nettype none
module mpra_ctl_model #(
    parameter int MOD_GAP = 4,
    parameter int WR_GAP = 3
) (
    input wire logic clk,
    output var mpra_pkg::mpra_cmd_t cmd
);
    logic [1:0] bl_r;

    // Idle command bus and burst field copy
    initial begin
        cmd = '{mpra_pkg::MPRA_OP_DES, 2'h0, 2'h0, 18'h0};
        bl_r = 2'h0;
    end

    // ----------------------------------------
    // Command issue, one per call
    // ----------------------------------------
    // Caller sits at a clock edge; the command is taken at the next one
    task automatic send(input mpra_pkg::mpra_op_t op, input logic [1:0] bg,
            input logic [1:0] ba, input logic [17:0] a, input int gap);
        mpra_pkg::mpra_cmd_t c;
        c = '{op, bg, ba, a};
        if (op == mpra_pkg::MPRA_OP_RD) begin
            c.addr[2:0] = 3'h0;
            c.addr[12] = c.addr[12] | (bl_r == 2'h1);
        end
        if (op == mpra_pkg::MPRA_OP_MRS && bg[0] == 1'b0 && ba == 2'h0) begin
            bl_r = a[1:0];
        end
        cmd <= c;
        @(posedge clk);
        // Idle bus shows flipped values, not the stale command
        cmd <= '{mpra_pkg::MPRA_OP_DES, ~c.bg, ~c.ba, ~c.addr};
        repeat (gap) @(posedge clk);
    endtask

    // Mode entry or exit, page 0 only, then the mode delay
    task automatic mr3(input logic en, input logic [1:0] fmt);
        send(mpra_pkg::MPRA_OP_MRS, 2'h0, 2'h3,
            {5'h00, fmt, 8'h00, en, 2'h0}, MOD_GAP);
    endtask

    task automatic mr0(input logic [1:0] bl);
        send(mpra_pkg::MPRA_OP_MRS, 2'h0, 2'h0, {16'h0, bl}, MOD_GAP);
    endtask

    // Pattern write, no inversion lane exists; recovery wait after
    task automatic wr(input logic [1:0] ba, input logic [7:0] d,
            input logic [9:0] junk);
        send(mpra_pkg::MPRA_OP_WR, 2'h3, ba, {junk, d}, WR_GAP);
    endtask

    task automatic rd(input logic [1:0] ba, input int gap);
        send(mpra_pkg::MPRA_OP_RD, 2'h1, ba, 18'h2A5F7, gap);
    endtask

    task automatic ref1x();
        send(mpra_pkg::MPRA_OP_REF, 2'h0, 2'h0, 18'h0, 2);
    endtask
endmodule
`default_nettype wire

// ### sim/mpra_top_tb_top.sv
// Self-checking bench for the MPR access logic
`timescale 1ns/1ps
`default_nettype none
module mpra_top_tb_top;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk;
    logic reset;
    mpra_pkg::mpra_cmd_t cmd;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic [3:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [7:0] dq8;
    logic dq8_oe;
    logic [15:0] dq16;
    logic dq16_oe;
    logic [7:0] pat [4];
    int mismatches;
    int compares;
    logic stag;

    mpra_ctl_model u_mpra_ctl_model (.clk(clk), .cmd(cmd));

    mpra_top #(.DQ_W(8)) u_mpra_top (.clk(clk), .reset(reset), .cmd(cmd),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .dq_o(dq8), .dq_oe(dq8_oe));

    // Wide part shares the bus so both see the same settings
    mpra_top #(.DQ_W(16)) u_mpra_top_w16 (.clk(clk), .reset(reset),
        .cmd(cmd), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(), .wb_ack_o(), .dq_o(dq16), .dq_oe(dq16_oe));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic load_pat();
        pat[0] = 8'h55;
        pat[1] = 8'h33;
        pat[2] = 8'h0F;
        pat[3] = 8'h00;
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] a);
        logic [7:0] v;
        for (int k = 0; k < 8; k++) v[k] = a[7-k];
        return v;
    endfunction

    // Staggered lane j carries location (ba + j) mod 4
    function automatic logic [7:0] lanes(input int ba, input int b);
        logic [7:0] v;
        for (int j = 0; j < 8; j++) v[j] = pat[stag ? (ba + j) % 4 : ba][b];
        return v;
    endfunction

    // One classic cycle; read data compared with exp
    task automatic wb(input logic we, input logic [3:0] adr,
            input logic [31:0] wd, input logic [31:0] exp);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            final_report();
        end
        if (!we) chk(wb_rdat, exp);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask

    // Checks nrd bursts from locations ba0, ba0+1.. with n driven beats
    task automatic stream(input int ba0, input int nrd, input int rl,
            input int n);
        logic [7:0] e;
        repeat (rl + 1) @(posedge clk);
        for (int r = 0; r < nrd; r++) begin
            for (int b = 0; b < 8; b++) begin
                if (r + b > 0) @(posedge clk);
                #1;
                e = lanes((ba0 + r) % 4, b);
                chk(dq8_oe, b < n);
                chk(dq16_oe, b < n);
                if (b < n) begin
                    chk(dq8, e);
                    chk(dq16, {e, e});
                end
            end
        end
        @(posedge clk);
        #1;
        chk(dq8_oe, 1'b0);
        @(posedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        wb(1'b0, mpra_pkg::REG_CFG, 0, 32'h0000000B);
        wb(1'b0, mpra_pkg::REG_DATA, 0, 32'h000F3355);
        wb(1'b1, mpra_pkg::REG_STAT, 32'hFF, 0);
        wb(1'b0, mpra_pkg::REG_STAT, 0, 0);
        wb(1'b0, 4'hC, 0, 0);
    endtask

    task automatic t_stagger();
        u_mpra_ctl_model.mr3(1'b1, 2'h2);
        u_mpra_ctl_model.ref1x();
        wb(1'b0, mpra_pkg::REG_STAT, 0, 32'h11);
        fork
            for (int i = 0; i < 4; i++) u_mpra_ctl_model.rd(2'(i), 7);
            stream(0, 4, 11, 8);
        join
    endtask

    task automatic t_write();
        u_mpra_ctl_model.wr(2'h2, 8'hC6, 10'h3FF);
        pat[2] = rev8(8'hC6);
        u_mpra_ctl_model.wr(2'h0, 8'h01, 10'h155);
        pat[0] = rev8(8'h01);
        wb(1'b0, mpra_pkg::REG_DATA, 0, {pat[3], pat[2], pat[1], pat[0]});
        fork
            begin
                u_mpra_ctl_model.rd(2'h2, 7);
                u_mpra_ctl_model.rd(2'h3, 7);
            end
            stream(2, 2, 11, 8);
        join
    endtask

    task automatic t_chop();
        wb(1'b1, mpra_pkg::REG_CFG, 32'h0002000B, 0);
        u_mpra_ctl_model.mr0(2'h2);
        fork
            u_mpra_ctl_model.rd(2'h1, 0);
            stream(1, 1, 13, 4);
        join
        // Serial format: every lane shows the addressed location
        u_mpra_ctl_model.mr3(1'b1, 2'h0);
        stag = 1'b0;
        fork
            u_mpra_ctl_model.rd(2'h2, 0);
            stream(2, 1, 13, 4);
        join
        stag = 1'b1;
    endtask

    task automatic t_exit();
        u_mpra_ctl_model.mr3(1'b0, 2'h2);
        wb(1'b0, mpra_pkg::REG_STAT, 0, 32'h50);
        fork
            u_mpra_ctl_model.rd(2'h0, 0);
            stream(0, 1, 13, 0);
        join
        u_mpra_ctl_model.wr(2'h3, 8'hFF, 10'h0);
        wb(1'b0, mpra_pkg::REG_DATA, 0, {pat[3], pat[2], pat[1], pat[0]});
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        load_pat();
        wb(1'b0, mpra_pkg::REG_DATA, 0, 32'h000F3355);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_sel = 4'hF;
        wb_wdat = 32'h0;
        mismatches = 0;
        compares = 0;
        stag = 1'b1;
        load_pat();
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_stagger();
        t_write();
        t_chop();
        t_exit();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
